/* File: include/scw_pkg.sv */
// Purpose: constants and carriers for the complex stream width converter
// Assumes: 12-bit signed components packed in 16-bit base units
// Notes: narrow side is one base unit per beat, wide side up to 8 units
package scw_pkg;
	localparam int CMP_W = 12;
	localparam int BU_W = 16;
	localparam int NU_MAX = 8;
	localparam int WIDE_W = 128;
	localparam int KEEP_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int LEN_W = 16;
	localparam int SUM_W = 24;
	localparam logic [1:0] MODE_W32 = 2'h0;
	localparam logic [1:0] MODE_W64 = 2'h1;
	localparam logic [1:0] MODE_W128 = 2'h2;
	localparam logic [3:0] UNITS_W32 = 4'h2;
	localparam logic [3:0] UNITS_W64 = 4'h4;
	localparam logic [3:0] UNITS_W128 = 4'h8;

	typedef struct packed {
		logic signed [CMP_W-1:0] real_component;
		logic signed [CMP_W-1:0] imaginary_component;
	} scw_cplx_s;

	typedef struct packed {
		logic [BU_W-1:0] data;
		logic last;
	} scw_unit_s;

	typedef struct packed {
		logic [WIDE_W-1:0] data;
		logic [KEEP_W-1:0] keep;
		logic last;
	} scw_wide_s;
endpackage : scw_pkg

/* File: logic/scw_converter.sv */
// Purpose: serial/parallel conversion of signed complex streams
// Assumes: single clock, synchronous active-low reset
// Notes: upsize path sample -> units -> fifo -> wide; downsize wide -> units
`timescale 1ns/1ps

module scw_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0] wr_ff;
	logic [AW:0] rd_ff;
	wire push = i_in_valid & o_in_ready;
	wire pop = o_out_valid & i_out_ready;
	wire full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
	wire empty = (wr_ff == rd_ff);

	assign o_in_ready = ~full;
	assign o_out_valid = ~empty;
	assign o_out_data = mem_ff[rd_ff[AW-1:0]];

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			if (push)
				wr_ff <= wr_ff + 1'b1;
			if (pop)
				rd_ff <= rd_ff + 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (push)
			mem_ff[wr_ff[AW-1:0]] <= i_in_data;
	end
endmodule : scw_fifo

module scw_converter
	import scw_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic [1:0] i_mode,
	input wire logic i_fix_en,
	input wire logic [LEN_W-1:0] i_fix_len,
	input wire logic [SUM_W-1:0] i_chk_expect,
	input wire logic i_smp_valid,
	output logic o_smp_ready,
	input wire scw_cplx_s i_smp,
	input wire logic i_smp_last,
	output logic o_up_valid,
	input wire logic i_up_ready,
	output scw_wide_s o_up,
	output logic o_chk_done,
	output logic o_chk_ok,
	input wire logic i_dn_valid,
	output logic o_dn_ready,
	input wire scw_wide_s i_dn,
	output logic o_nar_valid,
	input wire logic i_nar_ready,
	output logic [BU_W-1:0] o_nar_data,
	output logic o_nar_last
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	// units per wide beat for the selected width
	wire [3:0] units = (i_mode == MODE_W32) ? UNITS_W32 :
		(i_mode == MODE_W64) ? UNITS_W64 : UNITS_W128;

	// ---- serializer: one complex sample becomes two base units
	logic phase_ff;
	wire [CMP_W-1:0] cur_cmp = phase_ff ? i_smp.imaginary_component
		: i_smp.real_component;
	scw_unit_s fin;
	assign fin.data = {{(BU_W-CMP_W){cur_cmp[CMP_W-1]}}, cur_cmp};
	assign fin.last = phase_ff & i_smp_last;
	wire fifo_in_ready;
	wire push = i_smp_valid & fifo_in_ready;
	// sample retires only with its imaginary unit, so the master holds it meanwhile
	assign o_smp_ready = fifo_in_ready & phase_ff;

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn)
			phase_ff <= 1'b0;
		else if (push)
			phase_ff <= ~phase_ff;
	end

	// both units of one sample come from the same held input, real first
	sequence s_real_push;
		push && !phase_ff;
	endsequence

	a_sign_pad: assert property (
		push |-> fin.data[BU_W-1:CMP_W] == {(BU_W-CMP_W){fin.data[CMP_W-1]}})
		else $error("pad bits not sign copies");

	a_real_first: assert property (
		s_real_push |-> fin.data[CMP_W-1:0] == i_smp.real_component)
		else $error("real unit not sent first");

	a_real_imag: assert property (
		s_real_push |=> phase_ff && (o_smp_ready == push)
		&& (fin.data[CMP_W-1:0] == i_smp.imaginary_component))
		else $error("imaginary unit did not follow real");

	a_smp_stall: assert property (
		!fifo_in_ready |-> !o_smp_ready)
		else $error("sample retired while fifo full");

	wire fifo_out_valid;
	wire fifo_out_ready;
	scw_unit_s fout;
	scw_fifo #(
		.WIDTH($bits(scw_unit_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_in_valid(i_smp_valid),
		.o_in_ready(fifo_in_ready),
		.i_in_data(fin),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_out_ready),
		.o_out_data(fout)
	);

	// ---- upsizer
	logic [WIDE_W-1:0] acc_ff;
	logic [3:0] idx_ff;
	logic [LEN_W-1:0] len_ff;
	logic [SUM_W-1:0] sum_ff;
	logic up_valid_ff;
	scw_wide_s up_ff;
	logic chk_done_ff;
	logic chk_ok_ff;

	// output register frees in the cycle it is taken, so beats go back to back
	assign fifo_out_ready = ~up_valid_ff | i_up_ready;
	wire pop = fifo_out_valid & fifo_out_ready;
	wire len_end = (len_ff == i_fix_len - 1'b1);
	// fixed mode frames by count; the incoming marker is ignored there
	wire end_pkt = i_fix_en ? len_end : fout.last;
	wire [3:0] idx_nx = idx_ff + 4'h1;
	wire beat_full = (idx_nx == units) | end_pkt;
	wire [KEEP_W-1:0] keep_nx = ~(16'hFFFF << {idx_nx, 1'b0});

	// lane g takes the new unit at idx, older units below, zero above
	logic [WIDE_W-1:0] lanes;
	for (genvar g = 0; g < NU_MAX; g++) begin : g_lane
		assign lanes[g*BU_W +: BU_W] = (g == idx_ff) ? fout.data :
			(g < idx_ff) ? acc_ff[g*BU_W +: BU_W] : '0;
	end

	// checksum over significant bits only; pad bits never enter
	wire [SUM_W-1:0] unit_ext = {{(SUM_W-CMP_W){fout.data[CMP_W-1]}},
		fout.data[CMP_W-1:0]};
	wire [SUM_W-1:0] sum_nx = sum_ff + unit_ext;

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			acc_ff <= '0;
			idx_ff <= 4'h0;
			len_ff <= '0;
			sum_ff <= '0;
		end else if (pop) begin
			acc_ff <= lanes;
			idx_ff <= beat_full ? 4'h0 : idx_nx;
			len_ff <= end_pkt ? '0 : len_ff + 1'b1;
			sum_ff <= end_pkt ? '0 : sum_nx;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			up_valid_ff <= 1'b0;
			up_ff <= '0;
		end else if (pop && beat_full) begin
			up_valid_ff <= 1'b1;
			up_ff.data <= lanes;
			up_ff.keep <= keep_nx;
			up_ff.last <= end_pkt;
		end else if (i_up_ready) begin
			up_valid_ff <= 1'b0;
		end
	end

	// bits above the selected width are not part of the channel
	wire [KEEP_W-1:0] mode_mask = ~(16'hFFFF << {units, 1'b0});

	a_null_last: assert property (
		o_up_valid && ((o_up.keep & mode_mask) != mode_mask) |-> o_up.last)
		else $error("null bytes outside last beat");

	a_no_empty: assert property (
		o_up_valid |-> o_up.keep[1:0] == 2'h3)
		else $error("all-null beat emitted");

	a_full_beat: assert property (
		o_up_valid && !o_up.last |-> o_up.keep == mode_mask)
		else $error("middle beat not full width");

	a_keep_tail: assert property (
		o_up_valid |-> (o_up.keep & (o_up.keep + 16'h1)) == 16'h0
		&& (o_up.keep[15:1] & 15'h5555) == (o_up.keep[14:0] & 15'h5555))
		else $error("null lanes not a trailing run of whole units");

	a_up_hold: assert property (
		o_up_valid && !i_up_ready |=> o_up_valid && $stable(o_up))
		else $error("wide beat changed while stalled");

	a_last_pass: assert property (
		pop && !i_fix_en && fout.last |=> o_up_valid && o_up.last)
		else $error("end marker lost in upsizer");

	a_fix_len: assert property (
		pop && i_fix_en && len_end |=> o_up_valid && o_up.last)
		else $error("fixed length did not close packet");

	// a stray marker inside a fixed length packet must not flush a beat
	a_fix_ignore: assert property (
		pop && i_fix_en && !len_end && (idx_nx != units) |=> !o_up_valid)
		else $error("end marker closed a fixed length packet");

	a_len_clear: assert property (
		pop && end_pkt |=> len_ff == '0)
		else $error("unit count not restarted after packet");

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			chk_done_ff <= 1'b0;
			chk_ok_ff <= 1'b0;
		end else begin
			chk_done_ff <= pop & end_pkt;
			if (pop && end_pkt)
				chk_ok_ff <= (sum_nx == i_chk_expect);
		end
	end

	a_chk_time: assert property (
		pop && end_pkt |=> o_chk_done)
		else $error("checksum not reported on last");

	a_chk_pulse: assert property (
		!(pop && end_pkt) |=> !o_chk_done)
		else $error("checksum reported without last");

	a_chk_hold: assert property (
		!o_chk_done |-> $stable(o_chk_ok))
		else $error("checksum result moved between packets");

	a_chk_clear: assert property (
		pop && end_pkt |=> sum_ff == '0)
		else $error("checksum not restarted after packet");

	assign o_up_valid = up_valid_ff;
	assign o_up = up_ff;
	assign o_chk_done = chk_done_ff;
	assign o_chk_ok = chk_ok_ff;

	// ---- downsizer
	logic [WIDE_W-1:0] dbuf_ff;
	logic [3:0] dcnt_ff;
	logic dlast_ff;
	logic dbusy_ff;

	// keep is looked at only on the last beat; packed streams need no more
	logic [3:0] keep_units;
	always_comb begin
		keep_units = 4'h0;
		for (int k = 0; k < NU_MAX; k++)
			keep_units = keep_units + {3'h0, i_dn.keep[2*k]};
	end
	wire [3:0] dn_units = i_dn.last ? keep_units : units;
	wire nar_take = dbusy_ff & i_nar_ready;
	wire dn_final = nar_take & (dcnt_ff == 4'h1);
	assign o_dn_ready = ~dbusy_ff | dn_final;
	wire dn_load = i_dn_valid & o_dn_ready;

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			dbuf_ff <= '0;
			dcnt_ff <= 4'h0;
			dlast_ff <= 1'b0;
			dbusy_ff <= 1'b0;
		end else if (dn_load) begin
			// an all-null beat is dropped rather than sent as empty units
			dbuf_ff <= i_dn.data;
			dcnt_ff <= dn_units;
			dlast_ff <= i_dn.last;
			dbusy_ff <= (dn_units != 4'h0);
		end else if (nar_take) begin
			dbuf_ff <= {{BU_W{1'b0}}, dbuf_ff[WIDE_W-1:BU_W]};
			dcnt_ff <= dcnt_ff - 4'h1;
			dbusy_ff <= (dcnt_ff != 4'h1);
		end
	end

	assign o_nar_valid = dbusy_ff;
	assign o_nar_data = dbuf_ff[BU_W-1:0];
	assign o_nar_last = dlast_ff & (dcnt_ff == 4'h1);

	// narrow side checks
	sequence s_dn_load;
		dn_load && (dn_units != 4'h0);
	endsequence
	sequence s_first_unit(logic [BU_W-1:0] v);
		o_nar_valid && (o_nar_data == v);
	endsequence

	a_dn_order: assert property (
		s_dn_load |=> s_first_unit($past(i_dn.data[BU_W-1:0])))
		else $error("downsizer did not start with low unit");

	// each taken unit is followed by the next lane up, never a skip
	a_dn_next: assert property (
		nar_take && (dcnt_ff != 4'h1) |=> s_first_unit($past(dbuf_ff[2*BU_W-1:BU_W])))
		else $error("downsizer skipped a unit");

	a_dn_hold: assert property (
		o_nar_valid && !i_nar_ready |=> o_nar_valid && $stable(o_nar_data)
		&& $stable(o_nar_last))
		else $error("narrow unit changed while stalled");

	a_dn_refuse: assert property (
		o_nar_valid && !i_nar_ready |-> !o_dn_ready)
		else $error("wide beat accepted while units remain");

	a_dn_last: assert property (
		o_nar_valid && o_nar_last && i_nar_ready |-> o_dn_ready)
		else $error("narrow last misplaced");

	a_last_valid: assert property (
		o_nar_last |-> o_nar_valid)
		else $error("narrow last without a unit");
endmodule : scw_converter

/* File: bench/scw_sink.sv */
// Purpose: downstream stream slave model for the converter outputs
// Assumes: data captured on the rising edge where valid and ready meet
// Notes: ready drops one cycle in three so held outputs get exercised
`timescale 1ns/1ps

module scw_sink #(
	parameter int W = 145
) (
	input wire logic i_core_clk,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data
);
	logic [W-1:0] q[$];
	int cyc = 0;
	initial o_ready = 1'b0;
	always @(negedge i_core_clk) begin
		cyc <= cyc + 1;
		o_ready <= (cyc % 3) != 2;
	end
	always @(posedge i_core_clk) begin
		if (i_valid && o_ready) begin
			q.push_back(i_data);
		end
	end
endmodule : scw_sink

/* File: bench/scw_converter_tb.sv */
// Purpose: self-checking bench for the complex stream width converter
// Assumes: inputs driven on the falling edge, no random stimulus
// Notes: expected beats are rebuilt from the sample table
`timescale 1ns/1ps

module scw_converter_tb;
	import scw_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [1:0] i_mode = MODE_W32;
	logic i_fix_en = 1'b0;
	logic [LEN_W-1:0] i_fix_len = 16'h0001;
	logic [SUM_W-1:0] i_chk_expect = '0;
	logic i_smp_valid = 1'b0;
	scw_cplx_s i_smp = '0;
	logic i_smp_last = 1'b0;
	logic i_dn_valid = 1'b0;
	scw_wide_s i_dn = '0;
	logic o_smp_ready, o_up_valid, up_rdy, o_chk_done, o_chk_ok;
	logic o_dn_ready, o_nar_valid, nar_rdy, o_nar_last;
	scw_wide_s o_up;
	logic [BU_W-1:0] o_nar_data;
	logic chk_seen = 1'b0;
	logic ok_seen = 1'b0;
	int error_cnt = 0;
	int samples_checked = 0;
	scw_cplx_s smp[3] = '{'{12'hFFB, 12'h007}, '{12'h064, 12'h800}, '{12'h7FF, 12'hC01}};
	logic [BU_W-1:0] v[6] = '{16'h0001, 16'hFFFE, 16'h07FF, 16'hF800, 16'h0123, 16'hFEDC};

	always #5 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		if (o_chk_done === 1'b1) begin
			chk_seen <= 1'b1;
			ok_seen <= o_chk_ok;
		end
	end

	scw_converter u_dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_mode(i_mode),
		.i_fix_en(i_fix_en), .i_fix_len(i_fix_len), .i_chk_expect(i_chk_expect),
		.i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready), .i_smp(i_smp),
		.i_smp_last(i_smp_last), .o_up_valid(o_up_valid), .i_up_ready(up_rdy), .o_up(o_up),
		.o_chk_done(o_chk_done), .o_chk_ok(o_chk_ok), .i_dn_valid(i_dn_valid),
		.o_dn_ready(o_dn_ready), .i_dn(i_dn), .o_nar_valid(o_nar_valid),
		.i_nar_ready(nar_rdy), .o_nar_data(o_nar_data), .o_nar_last(o_nar_last));
	scw_sink u_up (.i_core_clk(i_core_clk), .i_valid(o_up_valid), .o_ready(up_rdy),
		.i_data(o_up));
	scw_sink u_nar (.i_core_clk(i_core_clk), .i_valid(o_nar_valid), .o_ready(nar_rdy),
		.i_data(145'({o_nar_data, o_nar_last})));

	function automatic logic [BU_W-1:0] sx(input logic [CMP_W-1:0] c);
		return {{4{c[CMP_W-1]}}, c};
	endfunction : sx

	task summarize;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	task tmo;
		error_cnt++;
		$display("wrong value handshake exp done got timeout");
		summarize();
	endtask : tmo

	task chk(input string n, input logic [144:0] e, input logic [144:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task waitq(input bit w);
		for (int t = 0; t < 200; t++) begin
			if ((w ? u_up.q.size() : u_nar.q.size()) > 0) return;
			@(negedge i_core_clk);
		end
		tmo();
	endtask : waitq

	// upstream keeps each sample fully packed and held until taken
	task put(input scw_cplx_s s, input logic l);
		logic r;
		@(negedge i_core_clk);
		i_smp_valid = 1'b1;
		i_smp = s;
		i_smp_last = l;
		for (int t = 0; t < 100; t++) begin
			#1 r = o_smp_ready;
			@(posedge i_core_clk);
			if (r === 1'b1) return;
			@(negedge i_core_clk);
		end
		tmo();
	endtask : put

	task dn_put(input scw_wide_s b);
		logic r;
		@(negedge i_core_clk);
		i_dn_valid = 1'b1;
		i_dn = b;
		for (int t = 0; t < 100; t++) begin
			#1 r = o_dn_ready;
			@(posedge i_core_clk);
			if (r === 1'b1) return;
			@(negedge i_core_clk);
		end
		tmo();
	endtask : dn_put

	task up_run(input logic [1:0] m, input int n, input int ns, input bit fix);
		logic [BU_W-1:0] u[$];
		scw_wide_s e;
		@(negedge i_core_clk);
		i_mode = m;
		i_fix_en = fix;
		i_fix_len = LEN_W'(2 * ns);
		for (int s = 0; s < ns; s++) begin
			put(smp[s], fix ? s == 0 : s == ns - 1);
			u.push_back(sx(smp[s].real_component));
			u.push_back(sx(smp[s].imaginary_component));
		end
		@(negedge i_core_clk);
		i_smp_valid = 1'b0;
		i_smp = ~i_smp;
		while (u.size() > 0) begin
			e = '0;
			for (int j = 0; j < n && u.size() > 0; j++) begin
				e.data[16*j +: 16] = u.pop_front();
				e.keep[2*j +: 2] = 2'h3;
			end
			e.last = u.size() == 0;
			waitq(1'b1);
			chk("o_up", e, u_up.q.pop_front());
		end
		repeat (2) @(negedge i_core_clk);
	endtask : up_run

	task t_w32;
		chk_seen = 1'b0;
		i_chk_expect = SUM_W'(-1946);
		up_run(MODE_W32, 2, 2, 1'b0);
		chk("chk_done", 1'b1, chk_seen);
		chk("chk_ok", 1'b1, ok_seen);
	endtask : t_w32

	task t_w64;
		chk_seen = 1'b0;
		i_chk_expect = '0;
		up_run(MODE_W64, 4, 3, 1'b0);
		chk("chk_done", 1'b1, chk_seen);
		chk("chk_ok", 1'b0, ok_seen);
	endtask : t_w64

	task t_w128;
		up_run(MODE_W128, 8, 3, 1'b0);
	endtask : t_w128

	// a stray end marker on the first sample must not close the packet
	task t_fix;
		up_run(MODE_W128, 8, 2, 1'b1);
	endtask : t_fix

	task t_dn;
		scw_wide_s b;
		@(negedge i_core_clk);
		i_mode = MODE_W64;
		b = '0;
		b.data[63:0] = {v[3], v[2], v[1], v[0]};
		b.keep = 16'h00FF;
		dn_put(b);
		b = '0;
		b.data[31:0] = {v[5], v[4]};
		b.keep = 16'h000F;
		b.last = 1'b1;
		dn_put(b);
		@(negedge i_core_clk);
		i_dn_valid = 1'b0;
		i_dn = ~i_dn;
		for (int k = 0; k < 6; k++) begin
			waitq(1'b0);
			chk("o_nar", {v[k], k == 5}, u_nar.q.pop_front());
		end
	endtask : t_dn

	initial begin
		repeat (8) @(posedge i_core_clk);
		@(negedge i_core_clk);
		i_rstn = 1'b1;
		chk("o_dn_ready", 1'b1, o_dn_ready);
		chk("o_up_valid", 1'b0, o_up_valid);
		chk("o_smp_ready", 1'b0, o_smp_ready);
		chk("o_nar_valid", 1'b0, o_nar_valid);
		chk("o_chk_done", 1'b0, o_chk_done);
		t_w32();
		t_w64();
		t_w128();
		t_fix();
		t_dn();
		summarize();
	end
endmodule : scw_converter_tb
